// ==== pbapfm_pin_mux.sv ====
// Summary of operation
// - Decoder variant: home pin resets to decoder.
// - Home pin also timer channel or GPIO.
// - Clock select drives prescaler clock out home.
// - Variant lacking function: reset to no function.
// - Serial clock drives as master, inputs as slave.
// - Port B 3..0 reset to serial functions.
// - Master drives master-out; slave receives it.
// - Slave drives master-in; master samples it.
// - Unselected slave floats its master-in output.
// - Slave select input marks transfer for slave.
// - Master-in is UART receive; select is transmit.
// - GPIO pins individually programmable in or out.
// - Port A 0..1 pulse outputs, reset default.
module pbapfm_pin_mux #(
	parameter bit HAS_DECODER = 1'b1,  // Part variant fitted with the quadrature decoder.
	parameter bit HAS_PULSE   = 1'b1   // Part variant fitted with the pulse-width outputs.
) (
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	// Pad side: one input, output and output enable per shared pin.
	input  wire logic [6:0] pad_in_i,
	output logic      [6:0] pad_out_o,
	output logic      [6:0] pad_oe_o,
	// Function select load; each select takes a pbapfm_fn_t code.
	input  wire logic       fsel_load_i,
	input  wire logic [1:0] fsel_home_i,
	input  wire logic [1:0] fsel_sclk_i,
	input  wire logic [1:0] fsel_mosi_i,
	input  wire logic [1:0] fsel_miso_i,
	input  wire logic [1:0] fsel_ss_i,
	input  wire logic [1:0] fsel_pa0_i,
	input  wire logic [1:0] fsel_pa1_i,
	output logic [13:0]     fsel_state_o,
	// Clock monitor.
	input  wire logic       clock_output_select_i,
	input  wire logic       prescaler_clock_i,
	// Quadrature decoder and timer.
	output logic            decoder_home_input_o,
	input  wire logic       timer_a_channel_3_out_i,
	input  wire logic       timer_a_channel_3_oe_i,
	output logic            timer_a_channel_3_in_o,
	// General-purpose ports.
	input  wire logic [4:0] port_b_out_i,
	input  wire logic [4:0] port_b_dir_i,
	output logic      [4:0] port_b_in_o,
	input  wire logic [1:0] port_a_out_i,
	input  wire logic [1:0] port_a_dir_i,
	output logic      [1:0] port_a_in_o,
	// First serial peripheral interface.
	input  wire logic       spi_master_i,
	input  wire logic       spi_first_serial_clock_i,
	output logic            spi_first_serial_clock_o,
	input  wire logic       spi_first_master_out_i,
	output logic            spi_first_master_out_o,
	input  wire logic       spi_first_master_in_i,
	output logic            spi_first_master_in_o,
	output logic            spi_first_slave_select_n_o,
	// Second serial communications interface.
	input  wire logic       uart_second_transmit_i,
	output logic            uart_second_receive_o,
	// Pulse-width outputs.
	input  wire logic       pulse_output_0_i,
	input  wire logic       pulse_output_1_i
);

	// Entire state of the mux, registered as one word.
	typedef struct packed {
		pbapfm_pkg::pbapfm_fn_t [6:0] fsel;       // Function chosen for each pin.
		logic [6:0]                   pad_out;    // Registered pad output levels.
		logic [6:0]                   pad_oe;     // Registered pad output enables.
		logic                         home;       // Home level to the decoder.
		logic                         tmr_in;     // Timer channel 3 capture input.
		logic [4:0]                   pb_in;      // Port B input readback.
		logic [1:0]                   pa_in;      // Port A input readback.
		logic                         sclk_in;    // Slave clock to the serial interface.
		logic                         mosi_in;    // Slave data in.
		logic                         miso_in;    // Master data in.
		logic                         ss_n;       // Slave select to the interface.
		logic                         rx;         // UART receive data.
	} pbapfm_state_t;

	// Reset choice for pins whose primary function may be missing on the part.
	localparam pbapfm_pkg::pbapfm_fn_t HOME_RESET_FN =
		HAS_DECODER ? pbapfm_pkg::FN_PRIMARY : pbapfm_pkg::FN_NONE;
	localparam pbapfm_pkg::pbapfm_fn_t PULSE_RESET_FN =
		HAS_PULSE ? pbapfm_pkg::FN_PRIMARY : pbapfm_pkg::FN_NONE;

	pbapfm_state_t state_r;    // Registered state.
	pbapfm_state_t state_nxt;  // Next state.
	logic [6:0]    pad_sync;   // Pad inputs after the synchroniser.
	logic [6:0]    gpio_out;   // GPIO drive levels in pad order.
	logic [6:0]    gpio_dir;   // GPIO directions in pad order, high means output.
	logic          slave_sel;  // Serial interface is an addressed slave.

	// Pad inputs come from outside, so they pass two flip-flops first.
	pbapfm_sync #(
		.WIDTH (pbapfm_pkg::PIN_COUNT)
	) u_pad_sync (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.async_i (pad_in_i),
		.sync_o  (pad_sync)
	);

	// Port B bits 4..0 sit on the first five pads in descending order.
	assign gpio_out = {port_a_out_i[1], port_a_out_i[0], port_b_out_i[0], port_b_out_i[1],
		port_b_out_i[2], port_b_out_i[3], port_b_out_i[4]};
	assign gpio_dir = {port_a_dir_i[1], port_a_dir_i[0], port_b_dir_i[0], port_b_dir_i[1],
		port_b_dir_i[2], port_b_dir_i[3], port_b_dir_i[4]};

	// A slave counts as addressed only while the external master holds select low.
	assign slave_sel = !spi_master_i
		&& (state_r.fsel[pbapfm_pkg::PIN_SS] == pbapfm_pkg::FN_PRIMARY)
		&& !pad_sync[pbapfm_pkg::PIN_SS];

	// Next-state logic: select loading, pad drivers and peripheral inputs.
	always_comb begin
		state_nxt = state_r;

		// New selections replace all seven at once so no pin sees a mixed set.
		if (fsel_load_i) begin
			state_nxt.fsel[pbapfm_pkg::PIN_HOME] = pbapfm_pkg::pbapfm_fn_t'(fsel_home_i);
			state_nxt.fsel[pbapfm_pkg::PIN_SCLK] = pbapfm_pkg::pbapfm_fn_t'(fsel_sclk_i);
			state_nxt.fsel[pbapfm_pkg::PIN_MOSI] = pbapfm_pkg::pbapfm_fn_t'(fsel_mosi_i);
			state_nxt.fsel[pbapfm_pkg::PIN_MISO] = pbapfm_pkg::pbapfm_fn_t'(fsel_miso_i);
			state_nxt.fsel[pbapfm_pkg::PIN_SS]   = pbapfm_pkg::pbapfm_fn_t'(fsel_ss_i);
			state_nxt.fsel[pbapfm_pkg::PIN_PA0]  = pbapfm_pkg::pbapfm_fn_t'(fsel_pa0_i);
			state_nxt.fsel[pbapfm_pkg::PIN_PA1]  = pbapfm_pkg::pbapfm_fn_t'(fsel_pa1_i);
		end

		// Every peripheral input starts at its idle level; only the owning pin overrides.
		state_nxt.pad_out = pbapfm_pkg::PAD_OUT_RESET;
		state_nxt.pad_oe  = pbapfm_pkg::PAD_OE_RESET;
		state_nxt.home    = 1'h0;
		state_nxt.tmr_in  = 1'h0;
		state_nxt.pb_in   = 5'h00;
		state_nxt.pa_in   = 2'h0;
		state_nxt.sclk_in = pbapfm_pkg::SCLK_IDLE_LEVEL;
		state_nxt.mosi_in = 1'h0;
		state_nxt.miso_in = 1'h0;
		state_nxt.ss_n    = pbapfm_pkg::SS_IDLE_LEVEL;
		state_nxt.rx      = pbapfm_pkg::RX_IDLE_LEVEL;

		// GPIO: each pin drives or reads according to its own direction bit.
		for (int i = 0; i < pbapfm_pkg::PIN_COUNT; i++) begin
			if (state_r.fsel[i] == pbapfm_pkg::FN_GPIO) begin
				state_nxt.pad_out[i] = gpio_out[i];
				state_nxt.pad_oe[i]  = gpio_dir[i];
			end
		end
		// Readback uses the same pad order as the drive vectors.
		for (int i = 0; i < 5; i++) begin
			if (state_r.fsel[4-i] == pbapfm_pkg::FN_GPIO) begin
				state_nxt.pb_in[i] = pad_sync[4-i];
			end
		end
		for (int i = 0; i < 2; i++) begin
			if (state_r.fsel[pbapfm_pkg::PIN_PA0+i] == pbapfm_pkg::FN_GPIO) begin
				state_nxt.pa_in[i] = pad_sync[pbapfm_pkg::PIN_PA0+i];
			end
		end

		// Home pin: the clock monitor takes priority once software selects it.
		if (clock_output_select_i) begin
			state_nxt.pad_out[pbapfm_pkg::PIN_HOME] = prescaler_clock_i;
			state_nxt.pad_oe[pbapfm_pkg::PIN_HOME]  = 1'h1;
		end else begin
			case (state_r.fsel[pbapfm_pkg::PIN_HOME])
				pbapfm_pkg::FN_PRIMARY: begin
					// Decoder home is input only; absent on the lesser part.
					if (HAS_DECODER) begin
						state_nxt.home = pad_sync[pbapfm_pkg::PIN_HOME];
					end
				end
				pbapfm_pkg::FN_ALT: begin
					// The timer owns both directions of the pin.
					state_nxt.pad_out[pbapfm_pkg::PIN_HOME] = timer_a_channel_3_out_i;
					state_nxt.pad_oe[pbapfm_pkg::PIN_HOME]  = timer_a_channel_3_oe_i;
					state_nxt.tmr_in = pad_sync[pbapfm_pkg::PIN_HOME];
				end
				default: begin
					// GPIO handled above; no function leaves the pin floating.
				end
			endcase
		end

		// Serial clock: direction follows the interface role.
		if (state_r.fsel[pbapfm_pkg::PIN_SCLK] == pbapfm_pkg::FN_PRIMARY) begin
			if (spi_master_i) begin
				state_nxt.pad_out[pbapfm_pkg::PIN_SCLK] = spi_first_serial_clock_i;
				state_nxt.pad_oe[pbapfm_pkg::PIN_SCLK]  = 1'h1;
			end else begin
				state_nxt.sclk_in = pad_sync[pbapfm_pkg::PIN_SCLK];
			end
		end

		// Master out: same one-cycle latency as the clock keeps the half-period lead.
		if (state_r.fsel[pbapfm_pkg::PIN_MOSI] == pbapfm_pkg::FN_PRIMARY) begin
			if (spi_master_i) begin
				state_nxt.pad_out[pbapfm_pkg::PIN_MOSI] = spi_first_master_out_i;
				state_nxt.pad_oe[pbapfm_pkg::PIN_MOSI]  = 1'h1;
			end else begin
				state_nxt.mosi_in = pad_sync[pbapfm_pkg::PIN_MOSI];
			end
		end

		// Master in: driven only by an addressed slave, otherwise high impedance.
		case (state_r.fsel[pbapfm_pkg::PIN_MISO])
			pbapfm_pkg::FN_PRIMARY: begin
				if (spi_master_i) begin
					state_nxt.miso_in = pad_sync[pbapfm_pkg::PIN_MISO];
				end else if (slave_sel) begin
					state_nxt.pad_out[pbapfm_pkg::PIN_MISO] = spi_first_master_in_i;
					state_nxt.pad_oe[pbapfm_pkg::PIN_MISO]  = 1'h1;
				end
			end
			pbapfm_pkg::FN_ALT: begin
				state_nxt.rx = pad_sync[pbapfm_pkg::PIN_MISO];
			end
			default: begin
				// GPIO handled above; no function leaves the pin floating.
			end
		endcase

		// Slave select: input to the interface, or the UART transmit output.
		case (state_r.fsel[pbapfm_pkg::PIN_SS])
			pbapfm_pkg::FN_PRIMARY: begin
				state_nxt.ss_n = pad_sync[pbapfm_pkg::PIN_SS];
			end
			pbapfm_pkg::FN_ALT: begin
				state_nxt.pad_out[pbapfm_pkg::PIN_SS] = uart_second_transmit_i;
				state_nxt.pad_oe[pbapfm_pkg::PIN_SS]  = 1'h1;
			end
			default: begin
				// GPIO handled above; no function leaves the pin floating.
			end
		endcase

		// Pulse outputs exist only on the fitted variant; ALT has no meaning here.
		if (HAS_PULSE && state_r.fsel[pbapfm_pkg::PIN_PA0] == pbapfm_pkg::FN_PRIMARY) begin
			state_nxt.pad_out[pbapfm_pkg::PIN_PA0] = pulse_output_0_i;
			state_nxt.pad_oe[pbapfm_pkg::PIN_PA0]  = 1'h1;
		end
		if (HAS_PULSE && state_r.fsel[pbapfm_pkg::PIN_PA1] == pbapfm_pkg::FN_PRIMARY) begin
			state_nxt.pad_out[pbapfm_pkg::PIN_PA1] = pulse_output_1_i;
			state_nxt.pad_oe[pbapfm_pkg::PIN_PA1]  = 1'h1;
		end
	end

	// State register; reset restores every pin's default function with pads released.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_r         <= '0;
			state_r.fsel[pbapfm_pkg::PIN_HOME] <= HOME_RESET_FN;
			state_r.fsel[pbapfm_pkg::PIN_SCLK] <= pbapfm_pkg::FN_PRIMARY;
			state_r.fsel[pbapfm_pkg::PIN_MOSI] <= pbapfm_pkg::FN_PRIMARY;
			state_r.fsel[pbapfm_pkg::PIN_MISO] <= pbapfm_pkg::FN_PRIMARY;
			state_r.fsel[pbapfm_pkg::PIN_SS]   <= pbapfm_pkg::FN_PRIMARY;
			state_r.fsel[pbapfm_pkg::PIN_PA0]  <= PULSE_RESET_FN;
			state_r.fsel[pbapfm_pkg::PIN_PA1]  <= PULSE_RESET_FN;
			state_r.sclk_in <= pbapfm_pkg::SCLK_IDLE_LEVEL;
			state_r.ss_n    <= pbapfm_pkg::SS_IDLE_LEVEL;
			state_r.rx      <= pbapfm_pkg::RX_IDLE_LEVEL;
		end else begin
			state_r <= state_nxt;
		end
	end

	// All outputs come straight from the state register.
	assign pad_out_o                  = state_r.pad_out;
	assign pad_oe_o                   = state_r.pad_oe;
	assign fsel_state_o               = state_r.fsel;
	assign decoder_home_input_o       = state_r.home;
	assign timer_a_channel_3_in_o     = state_r.tmr_in;
	assign port_b_in_o                = state_r.pb_in;
	assign port_a_in_o                = state_r.pa_in;
	assign spi_first_serial_clock_o   = state_r.sclk_in;
	assign spi_first_master_out_o     = state_r.mosi_in;
	assign spi_first_master_in_o      = state_r.miso_in;
	assign spi_first_slave_select_n_o = state_r.ss_n;
	assign uart_second_receive_o      = state_r.rx;

endmodule

// ==== pbapfm_pkg.sv ====
package pbapfm_pkg;

	// Number of shared pins handled by the mux.
	localparam int unsigned PIN_COUNT = 7;

	// Pin positions inside the pad vectors.
	localparam int unsigned PIN_HOME = 0;  // Home pin, port B bit 4.
	localparam int unsigned PIN_SCLK = 1;  // Serial clock pin, port B bit 3.
	localparam int unsigned PIN_MOSI = 2;  // Master out pin, port B bit 2.
	localparam int unsigned PIN_MISO = 3;  // Master in pin, port B bit 1.
	localparam int unsigned PIN_SS   = 4;  // Slave select pin, port B bit 0.
	localparam int unsigned PIN_PA0  = 5;  // Pulse output 0 pin, port A bit 0.
	localparam int unsigned PIN_PA1  = 6;  // Pulse output 1 pin, port A bit 1.

	// Synchroniser depth for every pin input.
	localparam int unsigned SYNC_STAGES = 2;

	// Per-pin function choice; PRIMARY and ALT mean different things per pin.
	typedef enum logic [1:0] {
		FN_NONE,
		FN_PRIMARY,
		FN_ALT,
		FN_GPIO
	} pbapfm_fn_t;

	// Idle levels handed to peripherals whose pin is routed elsewhere.
	localparam logic SS_IDLE_LEVEL   = 1'h1;
	localparam logic RX_IDLE_LEVEL   = 1'h1;
	localparam logic SCLK_IDLE_LEVEL = 1'h0;

	// Reset values of the pad drivers: nothing driven.
	localparam logic [PIN_COUNT-1:0] PAD_OUT_RESET = 7'h00;
	localparam logic [PIN_COUNT-1:0] PAD_OE_RESET  = 7'h00;

endpackage

// ==== pbapfm_sync.sv ====
// Two-stage synchroniser for a group of asynchronous pin inputs.
module pbapfm_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             clk_i,
	input  wire logic             reset_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	// First stage; only the second stage reads it.
	logic [WIDTH-1:0] meta_r;
	// Second stage; the only stage the rest of the design sees.
	logic [WIDTH-1:0] stable_r;

	// Both stages clear on reset so the outputs are defined from the start.
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			meta_r   <= '0;
			stable_r <= '0;
		end else begin
			meta_r   <= async_i;
			stable_r <= meta_r;
		end
	end

	assign sync_o = stable_r;

endmodule

// ==== pbapfm_pin_mux_checker.sv ====
// Watches the pin mux ports; each property ties a pad or select to its cause.
module pbapfm_pin_mux_checker #(
	parameter bit HAS_DECODER = 1'b1,
	parameter bit HAS_PULSE   = 1'b1
) (
	input wire logic        clk_i,
	input wire logic        reset_i,
	input wire logic [6:0]  pad_in_i,
	input wire logic [6:0]  pad_out_o,
	input wire logic [6:0]  pad_oe_o,
	input wire logic        fsel_load_i,
	input wire logic [1:0]  fsel_home_i,
	input wire logic [1:0]  fsel_sclk_i,
	input wire logic [1:0]  fsel_mosi_i,
	input wire logic [1:0]  fsel_miso_i,
	input wire logic [1:0]  fsel_ss_i,
	input wire logic [1:0]  fsel_pa0_i,
	input wire logic [1:0]  fsel_pa1_i,
	input wire logic [13:0] fsel_state_o,
	input wire logic        clock_output_select_i,
	input wire logic        prescaler_clock_i,
	input wire logic [1:0]  port_a_dir_i,
	input wire logic        spi_master_i,
	input wire logic        spi_first_serial_clock_i,
	input wire logic        spi_first_master_out_i,
	input wire logic        spi_first_slave_select_n_o,
	input wire logic        uart_second_transmit_i
);
	// Reset selection codes for this variant, pin 6 down to pin 0.
	localparam logic [1:0]  D   = HAS_DECODER ? 2'h1 : 2'h0;
	localparam logic [1:0]  P   = HAS_PULSE ? 2'h1 : 2'h0;
	localparam logic [13:0] DEF = {P, P, 8'h55, D};
	// All seven select inputs in the layout of the state output.
	logic [13:0] sel_in;
	assign sel_in = {fsel_pa1_i, fsel_pa0_i, fsel_ss_i, fsel_miso_i, fsel_mosi_i,
		fsel_sclk_i, fsel_home_i};
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	reset_default_a: assert property ($fell(reset_i) |-> fsel_state_o == DEF)
		else $error("select state wrong after reset");
	sel_load_a: assert property (fsel_load_i |=> fsel_state_o == $past(sel_in))
		else $error("select load not captured");
	home_clock_a: assert property (clock_output_select_i |=>
		pad_oe_o[0] && pad_out_o[0] == $past(prescaler_clock_i))
		else $error("prescaler clock not on home pad");
	sclk_master_a: assert property (spi_master_i && fsel_state_o[3:2] == 2'h1 |=>
		pad_oe_o[1] && pad_out_o[1] == $past(spi_first_serial_clock_i))
		else $error("serial clock not driven as master");
	sclk_slave_a: assert property (!spi_master_i && fsel_state_o[3:2] == 2'h1 |=>
		!pad_oe_o[1])
		else $error("serial clock driven as slave");
	mosi_master_a: assert property (spi_master_i && fsel_state_o[5:4] == 2'h1 |=>
		pad_oe_o[2] && pad_out_o[2] == $past(spi_first_master_out_i))
		else $error("master out not driven as master");
	miso_slave_a: assert property ($past(fsel_state_o[7:6] == 2'h1 && !reset_i) |->
		pad_oe_o[3] == ($past(!spi_master_i) && !spi_first_slave_select_n_o))
		else $error("master in drive does not follow select");
	uart_tx_a: assert property (fsel_state_o[9:8] == 2'h2 |=>
		pad_oe_o[4] && pad_out_o[4] == $past(uart_second_transmit_i))
		else $error("transmit data not on select pad");
	ss_sync_a: assert property ((!reset_i && fsel_state_o[9:8] == 2'h1) [*4] |->
		spi_first_slave_select_n_o == $past(pad_in_i[4], 3))
		else $error("select input not passed through");
	gpio_dir_a: assert property (fsel_state_o[13:12] == 2'h3 |=>
		pad_oe_o[6] == $past(port_a_dir_i[1]))
		else $error("port A bit 1 direction ignored");
endmodule

bind pbapfm_pin_mux pbapfm_pin_mux_checker #(
	.HAS_DECODER(HAS_DECODER),
	.HAS_PULSE(HAS_PULSE)
) u_chk (.*);

// ==== pbapfm_pad_model.sv ====
// Board side of the shared pins: external serial devices, encoder and drivers.
module pbapfm_pad_model (
	input  wire logic       clk_i,
	input  wire logic [6:0] pad_out_i,
	input  wire logic [6:0] pad_oe_i,
	input  wire logic [6:0] ext_oe_i,
	input  wire logic [6:0] ext_val_i,
	output logic      [6:0] pad_level_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [6:0] last_r = 7'h00; // Level each pin showed at the last edge.
	// The far master drives select and master out, the far slave master in,
	// only while the block has let go of that pin.
	// No pulls exist, so a pin nobody drives flips each cycle instead of holding.
	assign pad_level_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_oe_i & ext_val_i)
		| (~pad_oe_i & ~ext_oe_i & ~last_r);
	// Remember the level so that a floating pin can be inverted next cycle.
	always_ff @(posedge clk_i) begin
		last_r <= pad_level_o;
	end
endmodule

// ==== port_b_a_pin_function_mux_tb.sv ====
// Directed bench for the pin mux; each task drives one case and judges it.
module port_b_a_pin_function_mux_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk_i = 1'b0, reset_i = 1'b1, fsel_load_i = 1'b0;
	logic [1:0] fsel_home_i = 2'h1, fsel_sclk_i = 2'h1, fsel_mosi_i = 2'h1;
	logic [1:0] fsel_miso_i = 2'h1, fsel_ss_i = 2'h1, fsel_pa0_i = 2'h1, fsel_pa1_i = 2'h1;
	logic       clock_output_select_i = 1'b0, prescaler_clock_i = 1'b0, spi_master_i = 1'b0;
	logic       timer_a_channel_3_out_i = 1'b0, timer_a_channel_3_oe_i = 1'b0;
	logic [4:0] port_b_out_i = 5'h00, port_b_dir_i = 5'h00;
	logic [1:0] port_a_out_i = 2'h0, port_a_dir_i = 2'h0;
	logic       spi_first_serial_clock_i = 1'b0, spi_first_master_out_i = 1'b0;
	logic       spi_first_master_in_i = 1'b0, uart_second_transmit_i = 1'b0;
	logic       pulse_output_0_i = 1'b0, pulse_output_1_i = 1'b0;
	logic [6:0] ext_oe = 7'h00, ext_val = 7'h00; // Board drive of each pin.
	wire  [6:0] pad_in_i, pad_out_o, pad_oe_o, pad_oe_v;
	wire  [13:0] fsel_state_o, fsel_state_v;
	wire        decoder_home_input_o, timer_a_channel_3_in_o, spi_first_serial_clock_o;
	wire        spi_first_master_out_o, spi_first_master_in_o, spi_first_slave_select_n_o;
	wire        uart_second_receive_o;
	wire  [4:0] port_b_in_o;
	wire  [1:0] port_a_in_o;
	int         err_total = 0, num_checks = 0;
	pbapfm_pin_mux DUT (.*);
	// Variant without decoder and pulse outputs; it shares every input.
	pbapfm_pin_mux #(.HAS_DECODER(1'b0), .HAS_PULSE(1'b0)) DUT_V (.*, .pad_out_o(),
		.pad_oe_o(pad_oe_v), .fsel_state_o(fsel_state_v), .decoder_home_input_o(),
		.timer_a_channel_3_in_o(), .port_b_in_o(), .port_a_in_o(),
		.spi_first_serial_clock_o(), .spi_first_master_out_o(), .spi_first_master_in_o(),
		.spi_first_slave_select_n_o(), .uart_second_receive_o());
	pbapfm_pad_model u_board (.clk_i(clk_i), .pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o),
		.ext_oe_i(ext_oe), .ext_val_i(ext_val), .pad_level_o(pad_in_i));
	// The free-running system clock.
	always #10 clk_i = ~clk_i;
	// Counts a comparison and reports it at once if it misses.
	task automatic chk(input string nm, input logic [13:0] seen, input logic [13:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Lands just after an edge so registered outputs have settled.
	task automatic step(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// Loads all seven selects; pads follow one edge after the state.
	task automatic load(input logic [13:0] v);
		@(posedge clk_i);
		{fsel_pa1_i, fsel_pa0_i, fsel_ss_i, fsel_miso_i, fsel_mosi_i, fsel_sclk_i,
			fsel_home_i} <= v;
		fsel_load_i <= 1'b1;
		@(posedge clk_i);
		fsel_load_i <= 1'b0;
		step(1);
	endtask
	// Reset selections of both variants and the home input path.
	task automatic t_reset();
		chk("state", fsel_state_o, 14'h1555);
		chk("state_var", fsel_state_v, 14'h0154);
		chk("oe_var", {7'h00, pad_oe_v & 7'h61}, 14'h0000);
		@(posedge clk_i);
		ext_oe <= 7'h01;
		ext_val <= 7'h01;
		step(3);
		chk("home", {pad_oe_o[0], decoder_home_input_o}, 14'h1);
	endtask
	// Master role: clock and data leave together, far slave answers.
	task automatic t_master();
		@(posedge clk_i);
		spi_master_i <= 1'b1;
		spi_first_serial_clock_i <= 1'b1;
		ext_oe <= 7'h08;
		ext_val <= 7'h08;
		step(1);
		chk("m_pads", {pad_oe_o[3:1], pad_out_o[2:1]}, 14'h0D);
		spi_first_serial_clock_i <= 1'b0;
		spi_first_master_out_i <= 1'b1;
		step(1);
		chk("m_lead", pad_out_o[2:1], 14'h2);
		step(1);
		chk("m_in", spi_first_master_in_o, 14'h1);
	endtask
	// Slave role: master in floats until the far master selects us.
	task automatic t_slave();
		@(posedge clk_i);
		spi_master_i <= 1'b0;
		spi_first_master_in_i <= 1'b1;
		ext_oe <= 7'h16;
		ext_val <= 7'h16;
		// The clock pad is released one edge after the role change, then needs three more.
		step(4);
		chk("s_idle", {pad_oe_o[3:1], spi_first_serial_clock_o, spi_first_master_out_o},
			14'h03);
		ext_val <= 7'h06;
		step(3);
		chk("s_sel", {pad_oe_o[3], pad_out_o[3], spi_first_slave_select_n_o},
			14'h6);
		ext_val <= 7'h16;
		step(3);
		chk("s_unsel", pad_oe_o[3], 14'h0);
	endtask
	// Serial port on the master in and select pins.
	task automatic t_uart();
		ext_oe <= 7'h08;
		ext_val <= 7'h00;
		uart_second_transmit_i <= 1'b1;
		load(14'h1695);
		step(1);
		chk("uart", {pad_oe_o[4:3], pad_out_o[4], uart_second_receive_o,
			spi_first_slave_select_n_o}, 14'h15);
	endtask
	// Home pin as timer channel, port B bit 4 and clock monitor.
	task automatic t_home();
		timer_a_channel_3_out_i <= 1'b1;
		timer_a_channel_3_oe_i <= 1'b1;
		load(14'h1696);
		chk("tmr_out", {pad_oe_o[0], pad_out_o[0]}, 14'h3);
		timer_a_channel_3_oe_i <= 1'b0;
		ext_oe <= 7'h01;
		ext_val <= 7'h01;
		step(3);
		chk("tmr_in", {pad_oe_o[0], decoder_home_input_o, timer_a_channel_3_in_o}, 14'h1);
		port_b_dir_i <= 5'h10;
		port_b_out_i <= 5'h10;
		load(14'h1697);
		chk("gpio_out", {pad_oe_o[0], pad_out_o[0]}, 14'h3);
		port_b_dir_i <= 5'h00;
		step(3);
		chk("gpio_in", {pad_oe_o[0], port_b_in_o[4]}, 14'h1);
		clock_output_select_i <= 1'b1;
		prescaler_clock_i <= 1'b1;
		step(1);
		chk("clk_hi", {pad_oe_o[0], pad_out_o[0]}, 14'h3);
		prescaler_clock_i <= 1'b0;
		step(1);
		chk("clk_lo", {pad_oe_o[0], pad_out_o[0]}, 14'h2);
		clock_output_select_i <= 1'b0;
	endtask
	// Port A pins as pulse outputs, then as individually steered GPIO.
	task automatic t_port_a();
		pulse_output_0_i <= 1'b1;
		step(1);
		chk("pulse", {pad_oe_o[6:5], pad_out_o[6:5]}, 14'hD);
		port_a_dir_i <= 2'h1;
		port_a_out_i <= 2'h1;
		ext_oe <= 7'h40;
		ext_val <= 7'h40;
		load(14'h3D55);
		// Pin 6 is released only with the new selection, so its readback lags three edges.
		step(3);
		chk("gpio_a", {pad_oe_o[6:5], pad_out_o[5], port_a_in_o}, 14'h0F);
	endtask
	// Prints the tallies and the verdict, then stops the run.
	task automatic close_out();
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Main sequence: twenty cycles of reset, then every case in turn.
	initial begin
		repeat (20) @(posedge clk_i);
		reset_i <= 1'b0;
		step(2);
		t_reset();
		t_master();
		t_slave();
		t_uart();
		t_home();
		t_port_a();
		close_out();
	end
	// The whole run needs about 66 cycles; this cuts a hang short.
	initial begin
		repeat (2000) @(posedge clk_i);
		err_total++;
		close_out();
	end
endmodule
